/* inc/ddrba_pkg.sv */
package ddrba_pkg;

   // ------------------------------------------------------------
   // command decode and mode fields
   // ------------------------------------------------------------
   localparam int unsigned BURST_TYPE_BIT = 3;           // mode word bit selecting interleaved order
   localparam int unsigned BL_SHORT       = 4;           // burst of four
   localparam int unsigned BL_LONG        = 8;           // burst of eight
   localparam int unsigned AL_MAX         = 6;           // largest additive latency
   localparam int unsigned CL_MAX         = 7;           // largest cas latency
   localparam int unsigned LAT_MAX        = AL_MAX + CL_MAX; // largest read latency
   localparam int unsigned COL_W          = 12;          // column field incl. extra bit
   localparam int unsigned PAGE_COLS_NARROW = 2048;      // by-four page length
   localparam int unsigned PAGE_COLS_WIDE   = 1024;      // by-eight and by-sixteen page length

   // ------------------------------------------------------------
   // register map (word aligned)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_MODE   = 8'h00;            // bl, burst type, cl, al, org
   localparam logic [7:0] OFS_STATUS = 8'h04;            // live burst state
   localparam logic [7:0] OFS_COUNT  = 8'h08;            // read / write command counts
   localparam logic [7:0] OFS_LAST   = 8'h0c;            // last decoded start column

   localparam logic [31:0] MODE_RESET = 32'h0000_0030;   // bl4, sequential, cl3, al0, by-eight

   // mode word fields
   localparam int unsigned F_BL8  = 0;                   // 1 = burst of eight
   localparam int unsigned F_CL   = 4;                   // cl in bits 6:4
   localparam int unsigned F_AL   = 8;                   // al in bits 10:8
   localparam int unsigned F_X4   = 12;                  // 1 = by-four organisation

   typedef enum logic [1:0]
   {
      DDRBA_IDLE  = 2'b00,
      DDRBA_READ  = 2'b01,
      DDRBA_WRITE = 2'b10
   } ddrba_burst_e;

endpackage

/* design/ddrba_order.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// burst address order for one beat
// ------------------------------------------------------------
module ddrba_order
(
   input  wire logic [2:0] start_col,   // low start column bits
   input  wire logic [2:0] beat,        // beat number
   input  wire logic       bl8,         // burst of eight
   input  wire logic       ileave,      // interleaved order
   output logic      [2:0] col          // column of this beat
);

   // sequential wraps inside the nibble, upper bit toggles after four beats
   always_comb
   begin
      if (ileave)
         col = start_col ^ beat;
      else
         col = {start_col[2] ^ (bl8 & beat[2]), 2'(start_col[1:0] + beat[1:0])};
      if (!bl8)
         col[2] = start_col[2];
   end

endmodule
`default_nettype wire

/* design/ddrba_core.sv */
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module ddrba_core
#(
   parameter int unsigned DQ_W = 8                     // data width
)
(
   input  wire logic             hclk,         // system clock, 10 MHz
   input  wire logic             hresetn,      // async reset, active low
   input  wire logic             hsel,         // ahb select
   input  wire logic [31:0]      haddr,        // ahb address
   input  wire logic [1:0]       htrans,       // ahb transfer type
   input  wire logic             hwrite,       // ahb write
   input  wire logic [2:0]       hsize,        // ahb size
   input  wire logic [31:0]      hwdata,       // ahb write data
   input  wire logic             hready,       // ahb bus ready
   output logic      [31:0]      hrdata,       // ahb read data
   output logic                  hreadyout,    // ahb slave ready
   output logic                  hresp,        // ahb response, always okay
   input  wire logic             ck,           // link clock, sampled
   input  wire logic             cs_n,         // chip select
   input  wire logic             ras_n,        // row strobe
   input  wire logic             cas_n,        // column strobe
   input  wire logic             we_n,         // write enable
   input  wire logic [13:0]      addr,         // address pins
   input  wire logic [DQ_W-1:0]  dq_i,         // data in
   output logic      [DQ_W-1:0]  dq_o,         // data out
   output logic                  dq_oe,        // data drive enable
   input  wire logic             dqs_i,        // strobe in
   output logic                  dqs_o,        // strobe out
   output logic                  dqs_oe,       // strobe drive enable
   output logic      [ddrba_pkg::COL_W-1:0] beat_col, // column of current beat
   output logic                  beat_wr,      // pulse: write beat captured
   output logic      [DQ_W-1:0]  beat_wdata    // captured write data
);
   localparam int unsigned COLW = ddrba_pkg::COL_W;
   localparam int unsigned LM   = ddrba_pkg::LAT_MAX;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] ck_s1_q, ck_s2_q;                 // ck and dqs
   logic       ck_d_q;
   logic [3:0] cmd_s1_q, cmd_s2_q;
   logic [13:0] addr_s1_q, addr_s2_q;
   logic [DQ_W-1:0] dq_s1_q, dq_s2_q;

   // two flops on every pin; commands are sampled by the synced ck edge
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ck_s1_q   <= 2'h0;
         ck_s2_q   <= 2'h0;
         ck_d_q    <= 1'b0;
         cmd_s1_q  <= 4'hf;
         cmd_s2_q  <= 4'hf;
         addr_s1_q <= 14'h0;
         addr_s2_q <= 14'h0;
         dq_s1_q   <= '0;
         dq_s2_q   <= '0;
      end
      else
      begin
         ck_s1_q   <= {dqs_i, ck};
         ck_s2_q   <= ck_s1_q;
         ck_d_q    <= ck_s2_q[0];
         cmd_s1_q  <= {cs_n, ras_n, cas_n, we_n};
         cmd_s2_q  <= cmd_s1_q;
         addr_s1_q <= addr;
         addr_s2_q <= addr_s1_q;
         dq_s1_q   <= dq_i;
         dq_s2_q   <= dq_s1_q;
      end
   end

   wire ck_rise = ck_s2_q[0] & ~ck_d_q;
   wire ck_fall = ~ck_s2_q[0] & ck_d_q;

   // ------------------------------------------------------------
   // mode register and ahb slave
   // ------------------------------------------------------------
   logic [31:0] mode_q;
   logic [15:0] rd_cnt_q, wr_cnt_q;
   logic [COLW-1:0] last_col_q;
   logic        dph_q, dwr_q;
   logic [7:0]  dadr_q;
   ddrba_pkg::ddrba_burst_e burst_q;

   wire       bl8    = mode_q[ddrba_pkg::F_BL8];
   wire       ileave = mode_q[ddrba_pkg::BURST_TYPE_BIT];
   wire [2:0] cl     = mode_q[ddrba_pkg::F_CL +: 3];
   wire [2:0] al_raw = mode_q[ddrba_pkg::F_AL +: 3];
   // al of seven is not a legal setting; clamp to six
   wire [2:0] al     = (al_raw > 3'(ddrba_pkg::AL_MAX)) ? 3'(ddrba_pkg::AL_MAX) : al_raw;
   wire [3:0] rl     = 4'(al) + 4'(cl);
   wire [3:0] wl     = rl - 4'h1;
   wire       x4     = mode_q[ddrba_pkg::F_X4];

   // address phase latched; zero wait state response
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dph_q  <= 1'b0;
         dwr_q  <= 1'b0;
         dadr_q <= 8'h00;
      end
      else if (hready)
      begin
         dph_q  <= hsel & htrans[1];
         dwr_q  <= hwrite;
         dadr_q <= haddr[7:0];
      end
   end

   // mode register writes; hsize is not checked, so any write size loads the whole word
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mode_q <= ddrba_pkg::MODE_RESET;
      else if (dph_q && dwr_q && dadr_q == ddrba_pkg::OFS_MODE)
         mode_q <= hwdata & 32'h0000_1779;
   end

   // read mux registered to keep hrdata a flop; unmapped reads zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0;
      else if (hready && hsel && htrans[1] && !hwrite)
      begin
         case (haddr[7:0])
            ddrba_pkg::OFS_MODE:   hrdata <= mode_q;
            ddrba_pkg::OFS_STATUS: hrdata <= {30'h0, burst_q};
            ddrba_pkg::OFS_COUNT:  hrdata <= {wr_cnt_q, rd_cnt_q};
            ddrba_pkg::OFS_LAST:   hrdata <= {20'h0, last_col_q};
            default:               hrdata <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // command decode and latency pipeline
   // ------------------------------------------------------------
   wire col_cmd = ck_rise && !cmd_s2_q[3] && cmd_s2_q[2] && !cmd_s2_q[1];
   wire is_wr   = !cmd_s2_q[0];
   // by-four adds column bit eleven above the auto-precharge bit
   wire [COLW-1:0] cmd_col = x4 ? {addr_s2_q[11], 1'b0, addr_s2_q[9:0]}
                                : {2'b00, addr_s2_q[9:0]};

   // one slot per ck cycle of latency; a column command is held, never refused
   logic [LM:0]             pv_q;
   logic [LM:0]             pw_q;
   logic [LM:0][COLW-1:0]   pc_q;
   // stage inputs: the decoder feeds stage zero, every later stage its neighbour
   wire [LM:0]              pv_in = {pv_q[LM-1:0], col_cmd};
   wire [LM:0]              pw_in = {pw_q[LM-1:0], is_wr};
   wire [LM:0][COLW-1:0]    pc_in = {pc_q[LM-1:0], cmd_col};

   genvar gi;
   generate
      for (gi = 0; gi <= LM; gi++)
      begin : g_pipe
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               pv_q[gi] <= 1'b0;
               pw_q[gi] <= 1'b0;
               pc_q[gi] <= '0;
            end
            else if (ck_rise)
            begin
               pv_q[gi] <= pv_in[gi];
               pw_q[gi] <= pw_in[gi];
               pc_q[gi] <= pc_in[gi];
            end
         end
      end
   endgenerate

   // stage k holds a command issued k+1 ck edges ago
   wire [3:0] rd_tap = rl - 4'h1;
   wire [3:0] wr_tap = wl - 4'h1;
   wire rd_due = pv_q[rd_tap] & !pw_q[rd_tap];
   wire wr_due = pv_q[wr_tap] &  pw_q[wr_tap];
   wire rd_pre = (rd_tap != 4'h0) && pv_q[rd_tap-4'h1] && !pw_q[rd_tap-4'h1];

   // ------------------------------------------------------------
   // burst engine
   // ------------------------------------------------------------
   logic [2:0]      beat_q;
   logic [COLW-1:0] base_q;
   logic [3:0]      len_q;
   logic [2:0]      ocol;

   ddrba_order u_order
   (
      .start_col (base_q[2:0]),
      .beat      (beat_q),
      .bl8       (bl8),
      .ileave    (ileave),
      .col       (ocol)
   );

   wire [3:0] bl_n = bl8 ? 4'(ddrba_pkg::BL_LONG) : 4'(ddrba_pkg::BL_SHORT);

   // a new due command restarts the burst; that is the only early end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         burst_q <= ddrba_pkg::DDRBA_IDLE;
         beat_q  <= 3'h0;
         base_q  <= '0;
         len_q   <= 4'h0;
      end
      else if (ck_rise && (rd_due || wr_due))
      begin
         burst_q <= rd_due ? ddrba_pkg::DDRBA_READ : ddrba_pkg::DDRBA_WRITE;
         beat_q  <= 3'h0;
         base_q  <= rd_due ? pc_q[rd_tap] : pc_q[wr_tap];
         len_q   <= bl_n;
      end
      else if ((ck_rise || ck_fall) && burst_q != ddrba_pkg::DDRBA_IDLE)
      begin
         if (len_q <= 4'h1)
            burst_q <= ddrba_pkg::DDRBA_IDLE;
         else
            beat_q <= beat_q + 3'h1;
         len_q <= len_q - 4'h1;
      end
   end

   // beat column stays inside the page: only low bits move
   wire [COLW-1:0] cur_col = {base_q[COLW-1:3], ocol};

   // ------------------------------------------------------------
   // read drive and write capture
   // ------------------------------------------------------------
   logic pre_q;

   // preamble: strobe enabled low one ck before data
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pre_q <= 1'b0;
      else if (ck_rise)
         pre_q <= rd_pre;
   end

   // closing ck edge of a read carries no beat; stop there so no stray strobe rise leaks out
   wire rd_drive = burst_q == ddrba_pkg::DDRBA_READ && !(ck_rise && !rd_due && len_q <= 4'h1);

   // strobe follows ck while a read burst runs, so beat 0 rides a rising edge
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dqs_o  <= 1'b0;
         dqs_oe <= 1'b0;
         dq_oe  <= 1'b0;
         dq_o   <= '0;
      end
      else
      begin
         dqs_oe <= pre_q || rd_drive;
         dq_oe  <= rd_drive;
         dqs_o  <= rd_drive && ck_s2_q[0];
         dq_o   <= DQ_W'(cur_col);
      end
   end

   // write beats captured on synced strobe level change; extra data dropped
   logic dqs_d_q;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dqs_d_q    <= 1'b0;
         beat_wr    <= 1'b0;
         beat_wdata <= '0;
         beat_col   <= '0;
      end
      else
      begin
         dqs_d_q    <= ck_s2_q[1];
         beat_wr    <= burst_q == ddrba_pkg::DDRBA_WRITE && (ck_s2_q[1] != dqs_d_q);
         beat_wdata <= dq_s2_q;
         beat_col   <= cur_col;
      end
   end

   // ------------------------------------------------------------
   // statistics
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_cnt_q   <= 16'h0;
         wr_cnt_q   <= 16'h0;
         last_col_q <= '0;
      end
      else if (col_cmd)
      begin
         rd_cnt_q   <= rd_cnt_q + 16'(!is_wr);
         wr_cnt_q   <= wr_cnt_q + 16'(is_wr);
         last_col_q <= cmd_col;
      end
   end

endmodule
`default_nettype wire

/* dv/ddrba_core_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// port checker for the burst core
// ------------------------------------------------------------
module ddrba_core_sva
#(
   parameter int unsigned DQ_W = 8 // data width
)
(
   input wire logic        hclk,      // system clock
   input wire logic        hresetn,   // async reset
   input wire logic        hsel,      // ahb select
   input wire logic [1:0]  htrans,    // transfer type
   input wire logic        hwrite,    // ahb write
   input wire logic        hready,    // bus ready
   input wire logic [31:0] hrdata,    // read data
   input wire logic        hreadyout, // slave ready
   input wire logic        hresp,     // response
   input wire logic        dq_oe,     // data enable
   input wire logic        dqs_o,     // strobe out
   input wire logic        dqs_oe,    // strobe enable
   input wire logic        beat_wr    // write beat pulse
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // read address phase as the slave takes it
   wire logic rd_ap = hsel && htrans[1] && hready && !hwrite;

   chk_ready_high: assert property (hreadyout) else $error("slave inserted a wait");
   chk_resp_okay: assert property (!hresp) else $error("slave gave an error response");
   chk_rdata_hold: assert property (!$past(rd_ap) |-> $stable(hrdata)) else $error("read data moved");
   chk_strobe_data: assert property (dq_oe |-> dqs_oe) else $error("data driven without strobe");
   chk_preamble_low: assert property ($rose(dq_oe) |-> $past(dqs_oe, 4) && !$past(dqs_o, 1))
      else $error("no low strobe before first data");
   chk_burst_min: assert property ($rose(dq_oe) |-> dq_oe [*8]) else $error("read burst cut short");
   chk_wbeat_pulse: assert property (beat_wr |=> !beat_wr) else $error("write beat pulse too long");
   chk_dir_apart: assert property (beat_wr |-> !dq_oe) else $error("write capture while driving");
   chk_strobe_quiet: assert property ($changed(dqs_o) |-> dqs_oe || $past(dqs_oe))
      else $error("strobe toggled while released");

   cov_read: cover property ($rose(dq_oe));
   cov_write: cover property (beat_wr);
   cov_reg_read: cover property (rd_ap);
endmodule

bind ddrba_core ddrba_core_sva #(.DQ_W(DQ_W)) u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .beat_wr(beat_wr));
`default_nettype wire

/* dv/ddrba_ctl_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// controller side: commands and strobed write data
// ------------------------------------------------------------
module ddrba_ctl_model
#(
   parameter int unsigned DQ_W = 8 // data width
)
(
   output logic            ck,    // link clock
   output logic            cs_n,  // chip select
   output logic            ras_n, // row strobe
   output logic            cas_n, // column strobe
   output logic            we_n,  // write enable
   output logic [13:0]     addr,  // address pins
   output logic [DQ_W-1:0] dq_i,  // write data
   output logic            dqs_i  // write strobe
);
   // free running, phase unrelated to hclk
   initial
   begin
      ck = 1'b0;
      #137;
      forever #400 ck = ~ck;
   end
   // idle pins; strobe rests low, which serves as the write preamble
   initial
   begin
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      addr = 14'h0;
      dq_i = '0;
      dqs_i = 1'b0;
   end
   // no activate traffic: banks taken as open, so window limits hold trivially
   // a command is held one clock; a back to back call lands two clocks later
   task automatic cmd(input logic wr, input logic [11:0] col);
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n} <= {3'b010, ~wr};
      addr <= {2'b00, col};
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n} <= 4'hf;
      addr <= ~{2'b00, col};
   endtask
   // data set ahead of each strobe edge; two stray beats follow the burst
   task automatic wdat(input int wl, input int n);
      repeat (wl) @(posedge ck);
      #100;
      for (int k = 0; k < n + 2; k++)
      begin
         dq_i <= DQ_W'((k < n) ? 'ha0 + k : 'h5a);
         #200 dqs_i <= ~dqs_i;
         #200;
      end
      dq_i <= ~dq_i;
   endtask
endmodule
`default_nettype wire

/* dv/ddrba_core_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %0t %s", $time, m); end end
module ddrba_core_tb;
   // ------------------------------------------------------------
   // signals and test table
   // ------------------------------------------------------------
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, oe_q, sq_q;
   logic        ck, cs_n, ras_n, cas_n, we_n, dq_oe, dqs_i, dqs_o, dqs_oe, beat_wr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd, mw;
   logic [13:0] addr;
   logic [7:0]  dq_i, dq_o, beat_wdata, last_q;
   logic [11:0] beat_col, x, c;
   logic [23:0] e;
   logic [7:0]  rq[$];
   logic [19:0] wq[$];
   int          bad_count = 0, n_tests = 0, ck_n = 0, cyc = 0, nrd = 0, nwr = 0;
   int          t_pre, t_dat, rises, rl, bl, j, c0;
   // flags bl8 il x4 two, then cl, al, start column
   localparam logic [23:0] TBL [7] = '{24'h030001, 24'h43100b, 24'h842105, 24'he569fb,
                                       24'h8708a6, 24'h13100e, 24'h930011};

   // expected column of beat i; bit 11 only counts on by-four parts
   function automatic logic [11:0] ecol(logic [11:0] s, logic [2:0] i, logic il, logic x4);
      ecol = {s[11] & x4, 1'b0, s[9:3], s[2] ^ i[2], il ? s[1:0] ^ i[1:0] : s[1:0] + i[1:0]};
   endfunction

   // single word transfer; waits on the slave, never on a fixed count
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= 3'b010;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ------------------------------------------------------------
   // clocks, monitors, timeout
   // ------------------------------------------------------------
   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   always @(posedge ck) ck_n <= ck_n + 1;
   // beats are collected on change; columns of one stream never repeat back to back
   always @(posedge hclk)
   begin
      oe_q <= dq_oe;
      sq_q <= dqs_oe;
      last_q <= dq_o;
      if (dqs_oe && !sq_q) t_pre = ck_n;
      if (dq_oe && !oe_q)
      begin
         t_dat = ck_n;
         rises++;
      end
      if (dq_oe && (!oe_q || dq_o !== last_q)) rq.push_back(dq_o);
      if (beat_wr === 1'b1) wq.push_back({beat_col, beat_wdata});
   end
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         final_report();
      end
   end

   ddrba_core #(.DQ_W(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_i(dqs_i), .dqs_o(dqs_o),
      .dqs_oe(dqs_oe), .beat_col(beat_col), .beat_wr(beat_wr), .beat_wdata(beat_wdata));
   ddrba_ctl_model #(.DQ_W(8)) u_ctl (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .addr(addr), .dq_i(dq_i), .dqs_i(dqs_i));

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, ddrba_pkg::OFS_MODE, 32'h0, rd);
      `CHK(rd, ddrba_pkg::MODE_RESET, "mode reset value")
      ahb(1'b1, 8'h10, 32'hffff_ffff, rd);
      ahb(1'b0, 8'h10, 32'h0, rd);
      `CHK(rd, 32'h0, "unmapped read")
      ahb(1'b0, ddrba_pkg::OFS_MODE, 32'h0, rd);
      `CHK(rd, ddrba_pkg::MODE_RESET, "unmapped write leaked")
      ahb(1'b0, ddrba_pkg::OFS_STATUS, 32'h0, rd);
      `CHK(rd, 32'h0, "status reset value")
      $display("test registers done");
      for (int i = 0; i < 7; i++)
      begin
         e = TBL[i];
         bl = e[23] ? 8 : 4;
         rl = e[14:12] + e[18:16];
         mw = {19'h0, e[21], 1'b0, e[14:12], 1'b0, e[18:16], e[22], 2'b00, e[23]};
         ahb(1'b1, ddrba_pkg::OFS_MODE, mw, rd);
         ahb(1'b0, ddrba_pkg::OFS_MODE, 32'h0, rd);
         `CHK(rd, mw, "mode readback")
         rq.delete();
         rises = 0;
         u_ctl.cmd(1'b0, e[11:0]);
         c0 = ck_n;
         if (e[20])
            u_ctl.cmd(1'b0, e[11:0] ^ 12'h040);
         repeat (rl + 8) @(posedge ck);
         `CHK(t_dat - c0, rl, "read latency")
         `CHK(t_pre - c0, rl - 1, "read preamble")
         `CHK(rises, 1, "gap in read stream")
         `CHK(rq.size(), bl + (e[20] ? 4 : 0), "read beat count")
         for (int k = 0; k < rq.size(); k++)
         begin
            j = (e[20] && k >= 4) ? k - 4 : k;
            c = (e[20] && k >= 4) ? e[11:0] ^ 12'h040 : e[11:0];
            x = ecol(c, 3'(j), e[22], e[21]);
            `CHK(rq[k], x[7:0], "read column order")
         end
         nrd += e[20] ? 2 : 1;
         wq.delete();
         u_ctl.cmd(1'b1, e[11:0]);
         // status polled one ck into the write burst, while it surely runs
         fork
            u_ctl.wdat(rl - 1, bl);
            begin
               repeat (rl) @(posedge ck);
               ahb(1'b0, ddrba_pkg::OFS_STATUS, 32'h0, rd);
               `CHK(rd, 32'(ddrba_pkg::DDRBA_WRITE), "status during write")
            end
         join
         repeat (2) @(posedge ck);
         `CHK(wq.size(), bl, "write beat count")
         for (int k = 0; k < wq.size(); k++)
         begin
            x = ecol(e[11:0], 3'(k), e[22], e[21]);
            `CHK(wq[k], {x, 8'(8'ha0 + k)}, "write beat")
         end
         nwr++;
         $display("test burst %0d done", i);
      end
      ahb(1'b0, ddrba_pkg::OFS_COUNT, 32'h0, rd);
      `CHK(rd, {16'(nwr), 16'(nrd)}, "command counts")
      ahb(1'b0, ddrba_pkg::OFS_LAST, 32'h0, rd);
      `CHK(rd, 32'h0000_0011, "last start column")
      $display("test counters done");
      final_report();
   end
endmodule
`default_nettype wire
